// ---- dce_defs.svh ----
// Command codes, control bit positions and fixed values for the debug command engine
`ifndef DCE_DEFS_SVH
`define DCE_DEFS_SVH
`define DCE_OP_WR_CTL 8'h04
`define DCE_OP_RD_CTL 8'h05
`define DCE_OP_WR_PROG 8'h0a
`define DCE_OP_RD_PROG 8'h0b
`define DCE_OP_WR_DATA 8'h0c
`define DCE_OP_RD_DATA 8'h0d
`define DCE_OP_CRC 8'h0e
`define DCE_OP_STEP 8'h10
`define DCE_OP_STUFF 8'h11
`define DCE_OP_EXEC 8'h12
`define DCE_BIT_HALT 7
`define DCE_BIT_BREAKPOINT_ENABLE 6
`define DCE_BIT_ACK 5
`define DCE_BIT_SPIN 4
`define DCE_BIT_RST 0
`define DCE_CTL_RESERVED 3'h0
`define DCE_FILL_BYTE 8'hff
`define DCE_ACK_BYTE 8'hff
`define DCE_CRC_INIT 16'hffff
`define DCE_CRC_POLY 16'h1021
`define DCE_CRC_BLOCKED 16'hffff
`define DCE_FULL_COUNT 17'h10000
`define DCE_LAST_COUNT 17'h00001
`define DCE_ZERO_SIZE 16'h0000
`define DCE_PROG_BYTES 65536
`define DCE_FIFO_DEPTH 8
`endif

// ---- dce_engine.sv ----
// Debug command engine with its response FIFO
`timescale 1ns/1ps
`include "dce_defs.svh"

module dce_resp_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = `DCE_FIFO_DEPTH
) (
   input wire logic sys_clk_in,
   input wire logic rst_n_in,
   input wire logic ce_in,
   input wire logic in_valid_in,
   input wire logic [WIDTH-1:0] in_data_in,
   output logic in_ready_out,
   output logic out_valid_out,
   output logic [WIDTH-1:0] out_data_out,
   input wire logic out_ready_in
);
   localparam int CW = $clog2(DEPTH + 1);
   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [CW-1:0] count_reg;
   logic [CW-1:0] count_next;
   logic push;
   logic pop;
   assign in_ready_out = (count_reg != CW'(DEPTH));
   assign push = in_valid_in & in_ready_out;
   assign pop = out_valid_out & out_ready_in;
   assign count_next = count_reg + CW'(push) - CW'(pop);
   assign out_data_out = mem_reg[0];
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         count_reg <= '0;
         out_valid_out <= 1'b0;
      end else if (ce_in) begin
         count_reg <= count_next;
         out_valid_out <= (count_next != '0);
      end
   end
   // Head always sits in slot 0 so the output is a plain flop
   for (genvar i = 0; i < DEPTH; i++) begin : g_slot
      logic [WIDTH-1:0] above;
      if (i == DEPTH - 1) begin : g_top
         assign above = mem_reg[i];
      end else begin : g_mid
         assign above = mem_reg[i+1];
      end
      always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
         if (!rst_n_in) begin
            mem_reg[i] <= '0;
         end else if (ce_in) begin
            if (pop) begin
               mem_reg[i] <= (push && CW'(i + 1) == count_reg) ? in_data_in : above;
            end else if (push && CW'(i) == count_reg) begin
               mem_reg[i] <= in_data_in;
            end
         end
      end
   end
endmodule // dce_resp_fifo

//
// Functional notes
// - Program write: opcode, address high/low, size high/low, data; size zero is 65536.
// - Program write data dropped unless flash controller is unlocked.
// - Memory write data dropped outside debug mode or under read protection.
// - Program read returns size bytes, FFh when not halted or read protected.
// - Data write: opcode, address, size (zero is 65536), data stored to memory.
// - Data read returns bytes, FFh only outside debug mode.
// - CRC command reads all program memory, returns CRC-CCITT high byte first.
// - CRC outside debug mode answers FFFFh.
// - CRC answer follows about one clock per program byte; host waits.
// - Step runs one instruction; ignored unless halted and unprotected.
// - Stuff gives first opcode byte, rest fetched by CPU; same gating.
// - Execute forwards a 1-7 byte instruction, length from opcode; same gating.
// - Control write 81h resets and halts, 41h resets and runs, 40h resumes.
// - Debug-mode bit halts instruction fetch; clearing it resumes.
// - Enabled breakpoint with spin select clear sets debug-mode bit.
// - Under read protection a zero write to debug-mode bit is ignored.
// - With breakpoints disabled, the breakpoint opcode acts as a no-operation.
// - With acknowledge enabled, a breakpoint sends FFh to the host.
// - With spin select and breakpoints enabled, CPU loops instead of halting.
// - Reset-request bit resets all but the debug unit, clears when done.
// - Commands flow host to engine; results and acknowledges flow back.
module dce_engine
   import dce_pkg::*;
#(
   parameter int PROG_BYTES = `DCE_PROG_BYTES
) (
   input wire logic sys_clk_in,
   input wire logic rst_n_in,
   input wire logic ce_in,
   input wire logic cmd_valid_in,
   input wire logic [7:0] cmd_data_in,
   output logic cmd_ready_out,
   output logic resp_valid_out,
   output logic [7:0] resp_data_out,
   input wire logic resp_ready_in,
   output logic mem_req_out,
   output logic mem_write_out,
   output logic mem_prog_out,
   output logic [15:0] mem_addr_out,
   output logic [7:0] mem_wdata_out,
   input wire logic [7:0] mem_rdata_in,
   input wire logic mem_ack_in,
   input wire logic flash_unlocked_in,
   input wire logic read_protect_in,
   output logic cpu_halt_out,
   output logic breakpoint_enable_out,
   output logic break_spin_select_out,
   input wire logic breakpoint_opcode_in,
   output logic step_out,
   output logic stuff_out,
   output logic instr_valid_out,
   output logic [7:0] instr_byte_out,
   input wire logic [2:0] instr_len_in,
   input wire logic cpu_done_in,
   output logic sys_reset_req_out,
   input wire logic reset_done_in,
   output logic [7:0] debugger_control_out
);
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (!rst_n_in);

   dce_state_t state_reg, state_next;
   logic [7:0] op_reg, byte_reg, fsm_byte, fifo_in_data;
   logic [15:0] addr_reg, crc_reg;
   logic [16:0] rem_reg;
   logic halt_reg, breakpoint_enable_reg, acken_reg, spin_reg, rstreq_reg, ack_pend_reg;
   logic cmd_ready_reg, mem_req_reg, mem_write_reg, mem_prog_reg;
   logic step_reg, stuff_reg, instr_valid_reg;
   logic [7:0] instr_byte_reg;
   logic take, last, ex_ok, rd_ok, wr_ok, is_wr, is_rd, is_crc, ctl_wr, brk_hit;
   logic push_fsm, fifo_in_valid, fifo_ready, fsm_go, step_byte, mem_done;

   function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
      logic [15:0] r;
      r = c;
      for (int i = 7; i >= 0; i--) begin
         r = (r[15] ^ d[i]) ? ((r << 1) ^ `DCE_CRC_POLY) : (r << 1);
      end
      return r;
   endfunction

   assign take = cmd_valid_in & cmd_ready_reg;
   assign last = (rem_reg == `DCE_LAST_COUNT);
   assign ex_ok = halt_reg & ~read_protect_in;
   assign is_wr = (op_reg == `DCE_OP_WR_PROG) | (op_reg == `DCE_OP_WR_DATA);
   assign is_rd = (op_reg == `DCE_OP_RD_PROG) | (op_reg == `DCE_OP_RD_DATA);
   assign is_crc = (op_reg == `DCE_OP_CRC);
   assign rd_ok = (op_reg == `DCE_OP_RD_DATA) ? halt_reg : ex_ok;
   assign wr_ok = ex_ok & ((op_reg != `DCE_OP_WR_PROG) | flash_unlocked_in);
   assign ctl_wr = (state_reg == dce_st_ctl_data) & take;
   assign brk_hit = breakpoint_opcode_in & breakpoint_enable_reg;
   assign mem_done = (state_reg == dce_st_mem) & mem_req_reg & mem_ack_in;

   // Acknowledge byte has priority; the command stream waits behind it
   assign push_fsm = ((state_reg == dce_st_rd_push) | (state_reg == dce_st_crc_hi) |
                      (state_reg == dce_st_crc_lo)) & ~ack_pend_reg;
   always_comb begin
      fsm_byte = byte_reg;
      if (state_reg == dce_st_crc_hi) begin
         fsm_byte = crc_reg[15:8];
      end else if (state_reg == dce_st_crc_lo) begin
         fsm_byte = crc_reg[7:0];
      end else if (is_rd && !rd_ok) begin
         fsm_byte = `DCE_FILL_BYTE;
      end
   end
   assign fifo_in_valid = ack_pend_reg | push_fsm;
   assign fifo_in_data = ack_pend_reg ? `DCE_ACK_BYTE : fsm_byte;
   assign fsm_go = push_fsm & fifo_ready;
   assign step_byte = (mem_done & ~is_rd) | ((state_reg == dce_st_rd_push) & fsm_go) |
                      ((state_reg == dce_st_wr_byte) & take & ~wr_ok);

   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         dce_st_idle: begin
            if (take) begin
               case (cmd_data_in)
                  `DCE_OP_WR_CTL: state_next = dce_st_ctl_data;
                  `DCE_OP_RD_CTL: state_next = dce_st_rd_push;
                  `DCE_OP_WR_PROG, `DCE_OP_RD_PROG, `DCE_OP_WR_DATA, `DCE_OP_RD_DATA:
                     state_next = dce_st_addr_hi;
                  `DCE_OP_CRC: state_next = halt_reg ? dce_st_mem : dce_st_crc_hi;
                  `DCE_OP_STEP: state_next = ex_ok ? dce_st_cpu_wait : dce_st_idle;
                  `DCE_OP_STUFF: state_next = dce_st_stuff_op;
                  `DCE_OP_EXEC: state_next = dce_st_exec_byte;
                  default: state_next = dce_st_idle;
               endcase
            end
         end
         dce_st_addr_hi: if (take) state_next = dce_st_addr_lo;
         dce_st_addr_lo: if (take) state_next = dce_st_size_hi;
         dce_st_size_hi: if (take) state_next = dce_st_size_lo;
         dce_st_size_lo: begin
            if (take) begin
               if (is_wr) begin
                  state_next = dce_st_wr_byte;
               end else begin
                  state_next = rd_ok ? dce_st_mem : dce_st_rd_push;
               end
            end
         end
         dce_st_ctl_data: if (take) state_next = dce_st_idle;
         dce_st_wr_byte: begin
            if (take) begin
               if (wr_ok) begin
                  state_next = dce_st_mem;
               end else if (last) begin
                  state_next = dce_st_idle;
               end
            end
         end
         dce_st_mem: begin
            if (mem_done) begin
               if (is_rd) begin
                  state_next = dce_st_rd_push;
               end else if (is_crc) begin
                  state_next = last ? dce_st_crc_hi : dce_st_mem;
               end else begin
                  state_next = last ? dce_st_idle : dce_st_wr_byte;
               end
            end
         end
         dce_st_rd_push: begin
            if (fsm_go) begin
               if (last) begin
                  state_next = dce_st_idle;
               end else begin
                  state_next = rd_ok ? dce_st_mem : dce_st_rd_push;
               end
            end
         end
         dce_st_crc_hi: if (fsm_go) state_next = dce_st_crc_lo;
         dce_st_crc_lo: if (fsm_go) state_next = dce_st_idle;
         dce_st_stuff_op: begin
            if (take) state_next = ex_ok ? dce_st_cpu_wait : dce_st_idle;
         end
         dce_st_exec_byte: begin
            if (take) begin
               if (rem_reg == '0) begin
                  state_next = dce_st_exec_len;
               end else if (last) begin
                  state_next = ex_ok ? dce_st_cpu_wait : dce_st_idle;
               end
            end
         end
         dce_st_exec_len: begin
            if (instr_len_in <= 3'h1) begin
               state_next = ex_ok ? dce_st_cpu_wait : dce_st_idle;
            end else begin
               state_next = dce_st_exec_byte;
            end
         end
         dce_st_cpu_wait: if (cpu_done_in) state_next = dce_st_idle;
      endcase
   end

   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         state_reg <= dce_st_idle;
         cmd_ready_reg <= 1'b0;
      end else if (ce_in) begin
         state_reg <= state_next;
         cmd_ready_reg <= state_next inside {dce_st_idle, dce_st_addr_hi, dce_st_addr_lo,
            dce_st_size_hi, dce_st_size_lo, dce_st_ctl_data, dce_st_wr_byte,
            dce_st_stuff_op, dce_st_exec_byte};
      end
   end

   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         op_reg <= '0;
         addr_reg <= '0;
         rem_reg <= '0;
      end else if (ce_in) begin
         if (state_reg == dce_st_idle && take) begin
            op_reg <= cmd_data_in;
            addr_reg <= '0;
            rem_reg <= (cmd_data_in == `DCE_OP_CRC) ? 17'(PROG_BYTES) :
                       (cmd_data_in == `DCE_OP_EXEC) ? '0 : `DCE_LAST_COUNT;
         end else if (state_reg == dce_st_addr_hi && take) begin
            addr_reg[15:8] <= cmd_data_in;
         end else if (state_reg == dce_st_addr_lo && take) begin
            addr_reg[7:0] <= cmd_data_in;
         end else if (state_reg == dce_st_size_hi && take) begin
            rem_reg[15:8] <= cmd_data_in;
         end else if (state_reg == dce_st_size_lo && take) begin
            rem_reg <= ({rem_reg[15:8], cmd_data_in} == `DCE_ZERO_SIZE) ? `DCE_FULL_COUNT :
                       {1'b0, rem_reg[15:8], cmd_data_in};
         end else if (state_reg == dce_st_exec_len) begin
            rem_reg <= 17'(instr_len_in) - `DCE_LAST_COUNT;
         end else if (state_reg == dce_st_exec_byte && take && rem_reg != '0) begin
            rem_reg <= rem_reg - `DCE_LAST_COUNT;
         end else if (step_byte) begin
            addr_reg <= addr_reg + 16'h0001;
            rem_reg <= rem_reg - `DCE_LAST_COUNT;
         end
      end
   end

   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         byte_reg <= '0;
         crc_reg <= '0;
      end else if (ce_in) begin
         if (state_reg == dce_st_idle && take) begin
            byte_reg <= debugger_control_out;
            crc_reg <= halt_reg ? `DCE_CRC_INIT : `DCE_CRC_BLOCKED;
         end else if (state_reg == dce_st_wr_byte && take) begin
            byte_reg <= cmd_data_in;
         end else if (mem_done && is_rd) begin
            byte_reg <= mem_rdata_in;
         end else if (mem_done && is_crc) begin
            crc_reg <= crc_step(crc_reg, mem_rdata_in);
         end
      end
   end

   // Request stays up until acknowledged; a chained request follows at once
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         mem_req_reg <= 1'b0;
         mem_write_reg <= 1'b0;
         mem_prog_reg <= 1'b0;
      end else if (ce_in) begin
         mem_req_reg <= (state_next == dce_st_mem);
         mem_write_reg <= (state_next == dce_st_mem) & is_wr;
         mem_prog_reg <= (op_reg != `DCE_OP_WR_DATA) & (op_reg != `DCE_OP_RD_DATA);
      end
   end

   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         step_reg <= 1'b0;
         stuff_reg <= 1'b0;
         instr_valid_reg <= 1'b0;
         instr_byte_reg <= '0;
      end else if (ce_in) begin
         step_reg <= (state_reg == dce_st_idle) & take & (cmd_data_in == `DCE_OP_STEP) &
                     ex_ok;
         stuff_reg <= (state_reg == dce_st_stuff_op) & take & ex_ok;
         instr_valid_reg <= (state_reg == dce_st_exec_byte) & take & ex_ok;
         if (take && (state_reg == dce_st_stuff_op || state_reg == dce_st_exec_byte)) begin
            instr_byte_reg <= cmd_data_in;
         end
      end
   end

   // Breakpoint set wins over a same-cycle control write
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         halt_reg <= 1'b0;
         breakpoint_enable_reg <= 1'b0;
         acken_reg <= 1'b0;
         spin_reg <= 1'b0;
         rstreq_reg <= 1'b0;
      end else if (ce_in) begin
         if (brk_hit && !spin_reg) begin
            halt_reg <= 1'b1;
         end else if (ctl_wr) begin
            halt_reg <= cmd_data_in[`DCE_BIT_HALT] | (read_protect_in & halt_reg);
         end
         if (ctl_wr) begin
            breakpoint_enable_reg <= cmd_data_in[`DCE_BIT_BREAKPOINT_ENABLE];
            acken_reg <= cmd_data_in[`DCE_BIT_ACK];
            spin_reg <= cmd_data_in[`DCE_BIT_SPIN];
         end
         if (ctl_wr && cmd_data_in[`DCE_BIT_RST]) begin
            rstreq_reg <= 1'b1;
         end else if (reset_done_in) begin
            rstreq_reg <= 1'b0;
         end
      end
   end

   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ack_pend_reg <= 1'b0;
      end else if (ce_in) begin
         if (brk_hit && acken_reg) begin
            ack_pend_reg <= 1'b1;
         end else if (fifo_ready) begin
            ack_pend_reg <= 1'b0;
         end
      end
   end

   dce_resp_fifo #(.WIDTH(8), .DEPTH(`DCE_FIFO_DEPTH)) u_resp_fifo (
      .sys_clk_in(sys_clk_in),
      .rst_n_in(rst_n_in),
      .ce_in(ce_in),
      .in_valid_in(fifo_in_valid),
      .in_data_in(fifo_in_data),
      .in_ready_out(fifo_ready),
      .out_valid_out(resp_valid_out),
      .out_data_out(resp_data_out),
      .out_ready_in(resp_ready_in)
   );

   assign cmd_ready_out = cmd_ready_reg;
   assign mem_req_out = mem_req_reg;
   assign mem_write_out = mem_write_reg;
   assign mem_prog_out = mem_prog_reg;
   assign mem_addr_out = addr_reg;
   assign mem_wdata_out = byte_reg;
   assign cpu_halt_out = halt_reg;
   assign breakpoint_enable_out = breakpoint_enable_reg;
   assign break_spin_select_out = spin_reg;
   assign step_out = step_reg;
   assign stuff_out = stuff_reg;
   assign instr_valid_out = instr_valid_reg;
   assign instr_byte_out = instr_byte_reg;
   assign sys_reset_req_out = rstreq_reg;
   assign debugger_control_out = {halt_reg, breakpoint_enable_reg, acken_reg, spin_reg,
                                  `DCE_CTL_RESERVED, rstreq_reg};

   sequence s_step_cmd;
      state_reg == dce_st_idle && take && cmd_data_in == `DCE_OP_STEP && ex_ok;
   endsequence
   sequence s_pulse_once(sig);
      sig ##1 !sig;
   endsequence

   a_zero_size_full: assert property (state_reg == dce_st_size_lo && take &&
      rem_reg[15:8] == 8'h00 && cmd_data_in == 8'h00 |=> rem_reg == `DCE_FULL_COUNT)
      else $error("zero size not taken as full count");
   a_prog_wr_lock: assert property ($rose(mem_req_out) && mem_write_out && mem_prog_out
      |-> $past(flash_unlocked_in)) else $error("program write while flash locked");
   a_wr_blocked: assert property ($rose(mem_req_out) && mem_write_out |->
      $past(halt_reg) && !$past(read_protect_in)) else $error("write outside debug mode");
   a_rd_fill: assert property (push_fsm && state_reg == dce_st_rd_push && is_rd &&
      !(halt_reg && (op_reg == `DCE_OP_RD_DATA || !read_protect_in)) |->
      fifo_in_data == `DCE_FILL_BYTE) else $error("blocked read not filled");
   a_crc_blocked: assert property (state_reg == dce_st_idle && take &&
      cmd_data_in == `DCE_OP_CRC && !halt_reg |=> state_reg == dce_st_crc_hi &&
      crc_reg == `DCE_CRC_BLOCKED) else $error("blocked crc not ffff");
   a_step_pulse: assert property (s_step_cmd |=> s_pulse_once(step_out))
      else $error("step not a single pulse");
   a_protect_halt: assert property (ctl_wr && read_protect_in && halt_reg |=> halt_reg)
      else $error("protected halt cleared");
   a_brk_halts: assert property (brk_hit && !spin_reg |=> halt_reg)
      else $error("breakpoint did not halt");
   a_brk_spins: assert property (brk_hit && spin_reg && !halt_reg && !ctl_wr |=>
      !halt_reg) else $error("spin breakpoint halted");
   a_ack_byte: assert property (brk_hit && acken_reg |=> ack_pend_reg ##0
      (fifo_in_valid && fifo_in_data == `DCE_ACK_BYTE)) else $error("no acknowledge byte");
   a_rst_clear: assert property (sys_reset_req_out && reset_done_in && !ctl_wr
      |=> !sys_reset_req_out) else $error("reset request not cleared");
   a_addr_step: assert property (step_byte |=> addr_reg == $past(addr_reg) + 16'h0001)
      else $error("address did not advance");
endmodule // dce_engine

// ---- dce_pkg.sv ----
// Types shared by the debug command engine
package dce_pkg;
   typedef enum logic [14:0] {
      dce_st_idle = 15'h0001,
      dce_st_addr_hi = 15'h0002,
      dce_st_addr_lo = 15'h0004,
      dce_st_size_hi = 15'h0008,
      dce_st_size_lo = 15'h0010,
      dce_st_ctl_data = 15'h0020,
      dce_st_wr_byte = 15'h0040,
      dce_st_mem = 15'h0080,
      dce_st_rd_push = 15'h0100,
      dce_st_crc_hi = 15'h0200,
      dce_st_crc_lo = 15'h0400,
      dce_st_stuff_op = 15'h0800,
      dce_st_exec_byte = 15'h1000,
      dce_st_exec_len = 15'h2000,
      dce_st_cpu_wait = 15'h4000
   } dce_state_t;
endpackage

// ---- dce_target_model.sv ----
// Memory and processor stand-in for the debug command engine
`timescale 1ns/1ps
module dce_target_model (
   input wire logic sys_clk_in,
   input wire logic req_in,
   input wire logic wr_in,
   input wire logic prog_in,
   input wire logic [15:0] addr_in,
   input wire logic [7:0] wdata_in,
   output logic [7:0] rdata_out,
   output logic ack_out,
   input wire logic go_in,
   output logic done_out,
   input wire logic rst_req_in,
   output logic rst_done_out
);
   logic [7:0] mem_reg [0:255];
   logic slow_reg;
   logic [2:0] go_reg;
   initial begin
      for (int i = 0; i < 256; i++) mem_reg[i] = 8'(i * 7);
      {slow_reg, go_reg, ack_out, done_out, rst_done_out, rdata_out} = '0;
   end
   always @(posedge sys_clk_in) begin
      slow_reg <= ~slow_reg;
      ack_out <= 1'b0;
      // Stale read data is scrambled so a late sample cannot pass
      rdata_out <= ~rdata_out;
      if (req_in && !ack_out && slow_reg) begin
         ack_out <= 1'b1;
         rdata_out <= mem_reg[{prog_in, addr_in[6:0]}];
         if (wr_in) mem_reg[{prog_in, addr_in[6:0]}] <= wdata_in;
      end
      go_reg <= {go_reg[1:0], go_in};
      done_out <= go_reg[2];
      rst_done_out <= rst_req_in && !rst_done_out;
   end
endmodule // dce_target_model

// ---- debug_command_engine_bench.sv ----
// Self-checking bench for the debug command engine
`timescale 1ns/1ps
`include "dce_defs.svh"
module debug_command_engine_bench;
   logic clk = 0, rst_n = 0, cv = 0, rr = 0, unl = 0, rp = 0, bp = 0;
   logic [7:0] cd = 8'h00, rd, md, wd;
   logic [7:0] shad [0:255];
   logic [7:0] q [$];
   int seed = 21717, mismatches = 0, n_compared = 0, ngo = 0;
   logic req, wr, prog, ack, ready, rv, step, stuff, iv, rreq, rdone, done, halt, be, ss;
   logic [7:0] dc, ib;
   logic [2:0] ilen = 3'h1;
   logic [15:0] addr;
   always #5 clk = ~clk;
   dce_engine #(.PROG_BYTES(16)) dut (.sys_clk_in(clk), .rst_n_in(rst_n), .ce_in(1'b1),
      .cmd_valid_in(cv), .cmd_data_in(cd), .cmd_ready_out(ready), .resp_valid_out(rv),
      .resp_data_out(rd), .resp_ready_in(rr), .mem_req_out(req), .mem_write_out(wr),
      .mem_prog_out(prog), .mem_addr_out(addr), .mem_wdata_out(wd), .mem_rdata_in(md),
      .mem_ack_in(ack), .flash_unlocked_in(unl), .read_protect_in(rp),
      .cpu_halt_out(halt), .breakpoint_enable_out(be), .break_spin_select_out(ss),
      .breakpoint_opcode_in(bp), .step_out(step), .stuff_out(stuff),
      .instr_valid_out(iv), .instr_byte_out(ib), .instr_len_in(ilen), .cpu_done_in(done),
      .sys_reset_req_out(rreq), .reset_done_in(rdone), .debugger_control_out(dc));
   dce_target_model tm (.sys_clk_in(clk), .req_in(req), .wr_in(wr), .prog_in(prog),
      .addr_in(addr), .wdata_in(wd), .rdata_out(md), .ack_out(ack),
      .go_in(step | stuff | iv), .done_out(done), .rst_req_in(rreq), .rst_done_out(rdone));
   task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic give_verdict();
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // Byte held from a falling edge until the edge that takes it
   task automatic send(input logic [7:0] b);
      int t = 0;
      @(negedge clk);
      while (ready !== 1'b1 && t < 9999) begin
         t++;
         @(negedge clk);
      end
      if (t >= 9999) mismatches++;
      cv = 1'b1;
      cd = b;
      @(negedge clk);
      cv = 1'b0;
   endtask
   task automatic cmd(input logic [7:0] op, input logic [15:0] a, input logic [15:0] n);
      send(op);
      send(a[15:8]);
      send(a[7:0]);
      send(n[15:8]);
      send(n[7:0]);
   endtask
   task automatic stage(input string nm, input int go_exp);
      int t = 0;
      while (q.size() > 0 && t < 9999) begin
         t++;
         @(negedge clk);
      end
      check("queue_left", q.size(), 0);
      repeat (6) @(negedge clk);
      check("cpu_pulses", ngo, go_exp);
      $display("test %s done", nm);
   endtask
   task automatic rdmem(input logic [7:0] op, input logic [15:0] a, input int n, input bit blk);
      for (int i = 0; i < n; i++)
         q.push_back(blk ? `DCE_FILL_BYTE : shad[{op == 8'h0b, 7'(a + i)}]);
      cmd(op, a, 16'(n));
   endtask
   task automatic wrmem(input logic [7:0] op, input logic [15:0] a, input int n, input bit keep);
      logic [7:0] b;
      cmd(op, a, 16'(n));
      for (int i = 0; i < n; i++) begin
         b = 8'($random(seed));
         if (keep) shad[{op == 8'h0a, 7'(a + i)}] = b;
         send(b);
      end
   endtask
   task automatic ctl(input logic [7:0] v, input logic [7:0] e);
      send(8'h04);
      send(v);
      // Let a requested chip reset finish before reading back
      repeat (3) @(negedge clk);
      check("control", dc, e);
      check("brk_bits", {be, ss}, {e[6], e[4]});
      q.push_back(e);
      send(8'h05);
   endtask
   task automatic breakpoint_opcode(input bit ackd);
      if (ackd) q.push_back(`DCE_ACK_BYTE);
      @(negedge clk);
      bp = 1'b1;
      @(negedge clk);
      bp = 1'b0;
   endtask
   function automatic logic [15:0] crc16();
      logic [15:0] c = `DCE_CRC_INIT;
      for (int i = 0; i < 16; i++) begin
         c = c ^ {shad[128 + i], 8'h00};
         for (int k = 0; k < 8; k++)
            c = c[15] ? (c << 1) ^ `DCE_CRC_POLY : c << 1;
      end
      return c;
   endfunction
   always @(negedge clk) rr <= 1'($random(seed));
   always @(posedge clk) begin
      if ((step | stuff | iv) === 1'b1) ngo++;
      if (rv === 1'b1 && rr === 1'b1)
         check("resp", rd, q.size() > 0 ? {8'h00, q.pop_front()} : 16'h0100);
   end
   initial begin
      #200000;
      mismatches++;
      give_verdict();
   end
   initial begin
      for (int i = 0; i < 256; i++) shad[i] = 8'(i * 7);
      repeat (16) @(negedge clk);
      rst_n = 1'b1;
      rdmem(8'h0b, 16'h0000, 2, 1);
      wrmem(8'h0c, 16'h0010, 1, 0);
      q.push_back(8'(`DCE_CRC_BLOCKED >> 8));
      q.push_back(8'(`DCE_CRC_BLOCKED));
      send(8'h0e);
      send(8'h10);
      stage("running", 0);
      ctl(8'h81, 8'h80);
      stage("reset", 0);
      check("reset_req", rreq, 0);
      check("halt", halt, 1);
      wrmem(8'h0c, 16'h0010, 3, 1);
      rdmem(8'h0d, 16'h000f, 5, 0);
      wrmem(8'h0a, 16'h0003, 1, 0);
      unl = 1'b1;
      wrmem(8'h0a, 16'h0005, 2, 1);
      rdmem(8'h0b, 16'h0000, 9, 0);
      stage("memory", 0);
      q.push_back(8'(crc16() >> 8));
      q.push_back(8'(crc16()));
      send(8'h0e);
      send(8'h10);
      send(8'h11);
      send(8'h5a);
      ilen = 3'h3;
      send(8'h12);
      send(8'h5b);
      send(8'h01);
      send(8'h02);
      send(8'h0f);
      send(8'h13);
      ctl(8'h80, 8'h80);
      stage("crc_cpu", 5);
      check("instr_byte", ib, 8'h02);
      rp = 1'b1;
      ctl(8'h00, 8'h80);
      rdmem(8'h0b, 16'h0000, 1, 1);
      rdmem(8'h0d, 16'h0010, 1, 0);
      send(8'h10);
      stage("protect", 5);
      rp = 1'b0;
      ctl(8'h60, 8'h60);
      stage("resume", 5);
      check("halt", halt, 0);
      breakpoint_opcode(1);
      q.push_back(8'he0);
      send(8'h05);
      check("halt", halt, 1);
      stage("break", 5);
      ctl(8'h70, 8'h70);
      breakpoint_opcode(1);
      ctl(8'h70, 8'h70);
      ctl(8'h00, 8'h00);
      breakpoint_opcode(0);
      ctl(8'h00, 8'h00);
      stage("spin_nop", 5);
      give_verdict();
   end
endmodule // debug_command_engine_bench
